// ==== hdl/sms_defines.svh ====
// register offsets, field positions, reset values and timing counts of the spi master
`ifndef SMS_DEFINES_SVH
`define SMS_DEFINES_SVH
`define SMS_ADDR_CTRL     4'h0
`define SMS_ADDR_STAT     4'h1
`define SMS_ADDR_BUF      4'h2
`define SMS_ADDR_RATE     4'h3
`define SMS_ADDR_IRQ_STAT 4'h4
`define SMS_ADDR_IRQ_MASK 4'h5
`define SMS_CTRL_EN       7
`define SMS_CTRL_OUT_EN   6
`define SMS_CTRL_CPOL     4
`define SMS_CTRL_RATE_LSB 0
`define SMS_STAT_SMP      7
`define SMS_STAT_CKE      6
`define SMS_STAT_BUSY     1
`define SMS_STAT_FULL     0
`define SMS_IRQ_DONE      0
`define SMS_IRQ_OVF       1
`define SMS_CTRL_RESET    8'h00
`define SMS_STAT_RESET    8'h00
`define SMS_RATE_RESET    8'h00
`define SMS_BITS          4'h8
`define SMS_CLK_NS        40
`endif

// ==== hdl/sms_master.sv ====
// spi master transfer engine with register port and interrupt
// How it works
// - master drives serial clock, starts any time without slave request
// - buffer write immediately starts a full-duplex byte transfer
// - with output disabled, input still sampled at programmed rate
// - received byte copied to buffer, flags and interrupt set
// - clock idle level and active edge from polarity and edge bits
// - bytes leave most significant bit first
// - rate is fosc/4, /16, /64, timer/2 or fosc/(4*(divisor+1))
// - with edge bit set, data valid before first clock edge
// - sample phase bit chooses middle or end sampling point
// - output clock is also the internal shift clock
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/100ps
`include "sms_defines.svh"
module sms_master #(
    parameter int BITS = 8
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_srst,
    input  wire logic [3:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_sdi,
    input  wire logic       i_timer_out,
    output logic            o_sck,
    output logic            o_sdo,
    output logic            o_sdo_oe,
    output logic            o_irq
);
    initial begin
        if (BITS != 8) $error("only 8-bit transfers are supported");
    end

    logic [7:0]          ctrl_q;
    logic [7:0]          cfg_bits_q;
    logic [7:0]          rate_q;
    logic [7:0]          buf_q;
    logic [7:0]          sr_q;
    logic [1:0]          irq_stat_q;
    logic [1:0]          irq_mask_q;
    logic                full_q;
    logic [3:0]          bit_cnt_q;
    logic [9:0]          div_cnt_q;
    logic [2:0]          sdi_sync_q;
    logic                sdi_q;
    logic [2:0]          tmr_sync_q;
    logic                tmr_tgl_q;
    logic                sck_q;
    logic                sdo_q;
    logic                oe_q;
    logic                irq_q;
    logic [7:0]          rdata_q;
    sms_pkg::sms_state_e state_q;
    sms_pkg::sms_cfg_s   cfg;

    function automatic logic [9:0] half_period(input sms_pkg::sms_rate_e r,
                                               input logic [7:0] n);
        case (r)
            sms_pkg::SMS_DIV4:  half_period = 10'h001;
            sms_pkg::SMS_DIV16: half_period = 10'h007;
            sms_pkg::SMS_DIV64: half_period = 10'h01F;
            sms_pkg::SMS_DIVN:  half_period = {1'b0, n, 1'b1};
            default:            half_period = 10'h001;
        endcase
    endfunction

    assign cfg.enable = ctrl_q[`SMS_CTRL_EN];
    assign cfg.out_en = ctrl_q[`SMS_CTRL_OUT_EN];
    assign cfg.cpol   = ctrl_q[`SMS_CTRL_CPOL];
    assign cfg.cke    = cfg_bits_q[`SMS_STAT_CKE];
    assign cfg.input_sample_phase    = cfg_bits_q[`SMS_STAT_SMP];
    assign cfg.rate   = sms_pkg::sms_rate_e'(ctrl_q[2:0]);

    wire        wr_ctrl  = i_wr && (i_addr == `SMS_ADDR_CTRL);
    wire        wr_stat  = i_wr && (i_addr == `SMS_ADDR_STAT);
    wire        wr_buf   = i_wr && (i_addr == `SMS_ADDR_BUF);
    wire        wr_rate  = i_wr && (i_addr == `SMS_ADDR_RATE);
    wire        wr_istat = i_wr && (i_addr == `SMS_ADDR_IRQ_STAT);
    wire        wr_imask = i_wr && (i_addr == `SMS_ADDR_IRQ_MASK);
    wire        rd_buf   = i_rd && (i_addr == `SMS_ADDR_BUF);
    wire        busy     = (state_q != sms_pkg::SMS_IDLE);
    // timer rate: each rising timer pulse toggles, so one edge per timer/2 half
    wire        tmr_rise = tmr_sync_q[1] && !tmr_sync_q[2];
    wire        tick_div = (div_cnt_q == half_period(cfg.rate, rate_q));
    wire        tick     = (cfg.rate == sms_pkg::SMS_TMR2) ? tmr_rise : tick_div;
    wire        last_bit = (bit_cnt_q == `SMS_BITS - 4'h1);
    wire        start    = wr_buf && cfg.enable && !busy;
    wire        lead_end = (state_q == sms_pkg::SMS_LEAD) && tick;
    wire        trail_end = (state_q == sms_pkg::SMS_TRAIL) && tick;
    // sample at mid-bit or at end of bit
    wire        sample   = cfg.input_sample_phase ? trail_end : lead_end;
    wire        done     = trail_end && last_bit;
    wire [7:0]  sr_in    = {sr_q[6:0], sdi_q};
    wire [7:0]  stat_rd  = {cfg.input_sample_phase, cfg.cke, 4'h0, busy, full_q};
    wire [7:0]  rd_mux   = (i_addr == `SMS_ADDR_CTRL)     ? ctrl_q :
                           (i_addr == `SMS_ADDR_STAT)     ? stat_rd :
                           (i_addr == `SMS_ADDR_BUF)      ? buf_q :
                           (i_addr == `SMS_ADDR_RATE)     ? rate_q :
                           (i_addr == `SMS_ADDR_IRQ_STAT) ? {6'h00, irq_stat_q} :
                           (i_addr == `SMS_ADDR_IRQ_MASK) ? {6'h00, irq_mask_q} :
                                                            8'h00;
    wire        ovf_evt  = done && full_q && !rd_buf;
    // done and overflow set wins over clear
    wire [1:0]  istat_d  = (irq_stat_q & ~({2{wr_istat}} & i_wdata[1:0]))
                           | {ovf_evt, done};

    // three stages; only the second and third agree on a change
    always_ff @(posedge i_sys_clk) begin
        sdi_sync_q <= {sdi_sync_q[1:0], i_sdi};
        tmr_sync_q <= {tmr_sync_q[1:0], i_timer_out};
        if (sdi_sync_q[1] == sdi_sync_q[2]) begin
            sdi_q <= sdi_sync_q[2];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            ctrl_q     <= `SMS_CTRL_RESET;
            cfg_bits_q <= `SMS_STAT_RESET;
            rate_q     <= `SMS_RATE_RESET;
            irq_mask_q <= 2'h0;
            irq_stat_q <= 2'h0;
            rdata_q    <= 8'h00;
            irq_q      <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= i_wdata;
            if (wr_stat) cfg_bits_q <= i_wdata & 8'hC0;
            if (wr_rate) rate_q <= i_wdata;
            if (wr_imask) irq_mask_q <= i_wdata[1:0];
            irq_stat_q <= istat_d;
            rdata_q    <= i_rd ? rd_mux : 8'h00;
            irq_q      <= |(istat_d & irq_mask_q);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst || !busy || tick) begin
            div_cnt_q <= 10'h000;
        end else begin
            div_cnt_q <= div_cnt_q + 10'h001;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_q   <= sms_pkg::SMS_IDLE;
            bit_cnt_q <= 4'h0;
            sr_q      <= 8'h00;
            buf_q     <= 8'h00;
            full_q    <= 1'b0;
            sck_q     <= 1'b0;
            sdo_q     <= 1'b0;
            oe_q      <= 1'b0;
        end else begin
            oe_q <= cfg.enable && cfg.out_en;
            if (rd_buf) full_q <= 1'b0;
            if (sample) sr_q <= sr_in;
            case (state_q)
                sms_pkg::SMS_IDLE: begin
                    sck_q <= cfg.cpol;
                    if (start) begin
                        state_q   <= sms_pkg::SMS_LEAD;
                        bit_cnt_q <= 4'h0;
                        sr_q      <= i_wdata;
                        buf_q     <= i_wdata;
                        // msb first; valid before first edge
                        sdo_q     <= i_wdata[7];
                    end
                end
                sms_pkg::SMS_LEAD: begin
                    if (tick) begin
                        sck_q   <= ~cfg.cpol;
                        state_q <= sms_pkg::SMS_TRAIL;
                        // with edge bit clear data changes on the leading edge
                        if (!cfg.cke && bit_cnt_q != 4'h0) sdo_q <= sr_q[7];
                    end
                end
                sms_pkg::SMS_TRAIL: begin
                    if (tick) begin
                        sck_q <= cfg.cpol;
                        // stop after eight periods, clock idle
                        if (last_bit) begin
                            state_q <= sms_pkg::SMS_IDLE;
                            buf_q   <= cfg.input_sample_phase ? sr_in : sr_q;
                            full_q  <= 1'b1;
                        end else begin
                            state_q   <= sms_pkg::SMS_LEAD;
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            // next bit set up before its first edge
                            if (cfg.cke) sdo_q <= cfg.input_sample_phase ? sr_in[7] : sr_q[7];
                        end
                    end
                end
                default: state_q <= sms_pkg::SMS_IDLE;
            endcase
        end
    end

    // the driven clock is the shift clock; one register serves both
    // sampling continues regardless of output enable
    assign o_sck    = sck_q;
    assign o_sdo    = sdo_q;
    assign o_sdo_oe = oe_q;
    assign o_irq    = irq_q;
    assign o_rdata  = rdata_q;
endmodule

// ==== hdl/sms_pkg.sv ====
// types shared by the spi master
package sms_pkg;
    typedef enum logic [2:0] {
        SMS_DIV4  = 3'h0,
        SMS_DIV16 = 3'h1,
        SMS_DIV64 = 3'h2,
        SMS_TMR2  = 3'h3,
        SMS_DIVN  = 3'h4
    } sms_rate_e;
    typedef enum logic [2:0] {
        SMS_IDLE  = 3'h1,
        SMS_LEAD  = 3'h2,
        SMS_TRAIL = 3'h4
    } sms_state_e;
    typedef struct packed {
        logic       enable;
        logic       out_en;
        logic       cpol;
        logic       cke;
        logic       input_sample_phase;
        sms_rate_e  rate;
    } sms_cfg_s;
    typedef struct packed {
        logic sck;
        logic sdo;
        logic sdo_oe;
    } sms_pins_s;
endpackage

// ==== tb/sms_master_bench.sv ====
// self-checking bench for the spi master
`timescale 1ns/100ps
module sms_master_bench;
    logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, ld = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, stx = 8'h00, rdata, srx;
    logic       sck, sdo, oe, irq, sdi, cpol = 1'b0;
    int         n_errors = 0, samples_checked = 0, n;
    sms_master uut (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_sdi(sdi), .i_timer_out(1'b0), .o_sck(sck), .o_sdo(sdo),
        .o_sdo_oe(oe), .o_irq(irq));
    sms_spi_slave slv (.i_sys_clk(clk), .i_cpol(cpol), .i_load(ld), .i_tx(stx), .i_sck(sck),
        .i_sdo(sdo), .o_sdi(sdi), .o_rx(srx));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask
    task automatic close_out();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        rd_reg(4'h0, 8'h00);
        rd_reg(4'h1, 8'h00);
        rd_reg(4'h3, 8'h00);
        rd_reg(4'hF, 8'h00);
        // back-to-back strobes, no gap
        addr <= 4'h0;
        wdata <= 8'h13;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("ctrl back", 8'h13, rdata);
        addr <= 4'h3;
        wdata <= 8'hA5;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rate back", 8'hA5, rdata);
        wr_reg(4'h5, 8'h00);
        repeat (2) @(posedge clk);
        #1 chk("irq masked", 8'h00, {7'h00, irq});
        for (int k = 0; k < 2; k++) begin
            // divisor 3 gives eight cycles a half period on the divided path
            wr_reg(4'h3, 8'h03);
            wr_reg(4'h1, 8'h40);
            wr_reg(4'h5, 8'h01);
            cpol <= k[0];
            wr_reg(4'h0, {1'b1, ~k[0], 1'b0, k[0], 1'b0, k[0] ? 3'h4 : 3'h1});
            // idle level and output enable follow the control write one cycle later
            @(posedge clk);
            #1 chk("sck idle", {7'h00, k[0]}, {7'h00, sck});
            chk("sdo_oe", {7'h00, ~k[0]}, {7'h00, oe});
            stx <= k[0] ? 8'h5A : 8'h96;
            ld <= 1'b1;
            @(posedge clk);
            ld <= 1'b0;
            wr_reg(4'h2, k[0] ? 8'h3C : 8'hA5);
            for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge clk);
            chk("irq", 8'h01, {7'h00, irq});
            chk("slave rx", k[0] ? 8'h3C : 8'hA5, srx);
            chk("sck end", {7'h00, k[0]}, {7'h00, sck});
            rd_reg(4'h1, 8'h41);
            rd_reg(4'h2, k[0] ? 8'h5A : 8'h96);
            wr_reg(4'h4, 8'hFF);
            repeat (2) @(posedge clk);
            #1 chk("irq clear", 8'h00, {7'h00, irq});
        end
        close_out();
    end
endmodule

// ==== tb/sms_master_sva.sv ====
// port-level assertions for the spi master
`timescale 1ns/100ps
module sms_master_sva (
    input wire logic       i_sys_clk,
    input wire logic       i_srst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_sck,
    input wire logic       o_sdo_oe,
    input wire logic       o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    sequence ctrl_wr_s;
        i_wr && i_addr == 4'h0;
    endsequence
    sequence quiet_s;
        !i_wr && !i_rd;
    endsequence
    rdata_idle_a: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_rd_a: assert property (i_rd && i_addr > 4'h5 |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    ctrl_readback_a: assert property (ctrl_wr_s ##1 (i_rd && i_addr == 4'h0) // control held
        |=> o_rdata == $past(i_wdata, 2)) else $error("control readback wrong");
    rate_readback_a: assert property ((i_wr && i_addr == 4'h3) ##1 (i_rd && i_addr == 4'h3) // divisor held
        |=> o_rdata == $past(i_wdata, 2)) else $error("divisor readback wrong");
    oe_follow_a: assert property (ctrl_wr_s ##1 quiet_s // output enable
        |=> o_sdo_oe == ($past(i_wdata[7], 2) && $past(i_wdata[6], 2)))
        else $error("output enable wrong");
    sck_half_a: assert property ($changed(o_sck) |=> $stable(o_sck)) // half period
        else $error("serial clock half period too short");
    irq_mask_a: assert property ((i_wr && i_addr == 4'h5 && i_wdata == 8'h00) ##1 quiet_s // masked
        |=> !o_irq) else $error("masked interrupt high");
    irq_clear_a: assert property ((i_wr && i_addr == 4'h4 && i_wdata == 8'hFF) ##1 quiet_s // cleared
        |=> !o_irq) else $error("interrupt not cleared");
endmodule
bind sms_master sms_master_sva u_sva (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sck(o_sck),
    .o_sdo_oe(o_sdo_oe), .o_irq(o_irq));

// ==== tb/sms_spi_slave.sv ====
// behavioural spi slave: changes data on trailing edge, captures on leading edge
`timescale 1ns/100ps
module sms_spi_slave (
    input  wire logic       i_sys_clk,
    input  wire logic       i_cpol,
    input  wire logic       i_load,
    input  wire logic [7:0] i_tx,
    input  wire logic       i_sck,
    input  wire logic       i_sdo,
    output logic            o_sdi,
    output logic      [7:0] o_rx
);
    logic [7:0] sh;
    logic [3:0] cnt;
    logic       sck_q;
    initial begin
        o_sdi = 1'b0;
        o_rx = 8'h00;
        sh = 8'h00;
        cnt = 4'h8;
        sck_q = 1'b0;
    end
    // msb first, bit ready before leading edge
    always @(posedge i_sys_clk) begin
        sck_q <= i_sck;
        if (i_load) begin
            sh <= i_tx;
            o_sdi <= i_tx[7];
            cnt <= 4'h0;
        end else if (sck_q == i_cpol && i_sck != i_cpol) begin
            o_rx <= {o_rx[6:0], i_sdo};
        end else if (sck_q != i_cpol && i_sck == i_cpol && cnt < 4'h8) begin
            sh <= {sh[6:0], 1'b0};
            cnt <= cnt + 4'h1;
            // released after the last bit: show the inverse, not a held value
            o_sdi <= (cnt == 4'h7) ? ~o_sdi : sh[6];
        end
    end
endmodule
